// >>> include/aef_pkg.sv
// Package of constants and types for the escaped frame encoder
//------------------------------------------------------------------------------
// Function
// RL1 - After the start marker every byte equal to the marker is sent twice.
// RL2 - Receiver syncs on non-marker, lone marker, then a reply type byte.
// RL3 - Frame opens with marker, type byte, then six timestamp bytes.
// RL4 - Level byte then 2, 7 or 14 reply bytes with matching type.
// RL5 - Timestamp is a 12 MHz count at reception, most significant first.
// RL6 - Timestamp counter runs free with no external alignment.
// RL7 - Unknown timestamp is sent as six zero bytes.
// RL8 - Unknown signal level is sent as all ones.
// RL9 - Frame may reach two plus twice the summed field length in bytes.
// RL10 - Doubling covers timestamp, level and reply bytes alike.
// RL11 - Bytes leave one at a time by valid/ready, frames never interleave.
//------------------------------------------------------------------------------
package aef_pkg;

	localparam logic [7:0] MARKER      = 8'h1A;
	localparam logic [7:0] TYPE_AC     = 8'h31;
	localparam logic [7:0] TYPE_SHORT  = 8'h32;
	localparam logic [7:0] TYPE_LONG   = 8'h33;
	localparam logic [7:0] TS_NONE     = 8'h00;
	localparam logic [7:0] LEVEL_NONE  = 8'hFF;

	localparam int         TS_BYTES    = 6;
	localparam int         TS_W        = TS_BYTES * 8;
	localparam int         DATA_BYTES  = 14;
	localparam int         LEN_AC      = 2;
	localparam int         LEN_SHORT   = 7;
	localparam int         LEN_LONG    = 14;
	// Body index: 0 type, 1..6 timestamp, 7 level, 8.. reply bytes
	localparam logic [4:0] IDX_LEVEL   = 5'h07;
	localparam logic [4:0] IDX_DATA    = 5'h08;

	// Timestamp tick rate from the system clock rate, in MHz
	localparam int         CLK_MHZ     = 20;
	localparam int         TICK_MHZ    = 12;
	localparam logic [4:0] ACC_STEP    = 5'(TICK_MHZ);
	localparam logic [4:0] ACC_WRAP    = 5'(CLK_MHZ);

	typedef enum logic [1:0] {
		AEF_AC,
		AEF_SHORT,
		AEF_LONG
	} aef_kind_e;

	typedef struct packed {
		aef_kind_e                   kind;
		logic [7:0]                  level;
		logic                        level_ok;
		logic                        ts_ok;
		logic [DATA_BYTES*8-1:0]     data;
	} aef_reply_s;

endpackage

// >>> test/aef_encoder_properties.sv
// Checker for the escaped frame encoder ports
`timescale 1ns/1ps
module aef_encoder_properties
(
	input logic                clk,
	input logic                rst_b,
	input aef_pkg::aef_reply_s rep,
	input logic                rep_valid,
	input logic                rep_ready,
	input logic [7:0]          tx_data,
	input logic                tx_valid,
	input logic                tx_ready
);
	aef_pkg::aef_reply_s r_ff;
	logic [4:0]          pos_ff;
	logic                odd_ff;
	logic [7:0]          want;
	logic [4:0]          last;
	logic                acc;
	logic                tk;
	assign acc = rep_valid && rep_ready;
	assign tk = tx_valid && tx_ready;
	assign last = r_ff.kind == aef_pkg::AEF_AC ? 5'h0B :
		r_ff.kind == aef_pkg::AEF_SHORT ? 5'h10 : 5'h17;
	always_comb
		if (pos_ff == 5'h01)
			want = 8'h31 + 8'(r_ff.kind);
		else if (pos_ff == 5'h08)
			want = r_ff.level_ok ? r_ff.level : 8'hFF;
		else
			want = r_ff.data[111 - 8 * (int'(pos_ff) - 9) -: 8];
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			{pos_ff, odd_ff} <= '0;
		else if (acc)
			{pos_ff, odd_ff, r_ff} <= {5'h00, 1'b0, rep};
		else if (tk && !odd_ff && pos_ff != 0 && tx_data == 8'h1A)
			odd_ff <= 1'b1;
		else if (tk)
			{pos_ff, odd_ff} <= {pos_ff + 5'h01, 1'b0};
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_hold;
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
	endproperty
	a_hold: assert property (p_hold) else $error("byte dropped");
	property p_start;
		acc |=> tx_valid && tx_data == 8'h1A && !rep_ready;
	endproperty
	a_start: assert property (p_start) else $error("bad start");
	property p_type;
		tx_valid && pos_ff == 5'h01 |-> tx_data == want;
	endproperty
	a_type: assert property (p_type) else $error("bad type");
	property p_ts;
		tx_valid && pos_ff inside {[2:7]} && !r_ff.ts_ok |-> tx_data == 8'h00;
	endproperty
	a_ts: assert property (p_ts) else $error("bad empty stamp");
	property p_lvl;
		tx_valid && pos_ff == 5'h08 |-> tx_data == want;
	endproperty
	a_lvl: assert property (p_lvl) else $error("bad level");
	property p_data;
		tx_valid && pos_ff > 5'h08 |-> tx_data == want;
	endproperty
	a_data: assert property (p_data) else $error("bad reply");
	property p_dbl;
		odd_ff |-> tx_valid && tx_data == 8'h1A;
	endproperty
	a_dbl: assert property (p_dbl) else $error("lone marker");
	property p_one;
		tx_valid |-> !rep_ready;
	endproperty
	a_one: assert property (p_one) else $error("overlap");
	property p_len;
		$rose(rep_ready) |-> pos_ff == last;
	endproperty
	a_len: assert property (p_len) else $error("bad length");
	cover property (acc && rep.kind == aef_pkg::AEF_LONG);
	cover property (odd_ff);
	cover property (tx_valid && !tx_ready);
endmodule
bind aef_encoder aef_encoder_properties aef_encoder_properties_i (.clk, .rst_b,
	.rep, .rep_valid, .rep_ready, .tx_data, .tx_valid, .tx_ready);

// >>> test/aef_encoder_test.sv
// Testbench for the escaped frame encoder
`timescale 1ns/1ps
module aef_encoder_test;
	logic                clk = 1'b0;
	logic                rst_b = 1'b0;
	logic                rep_valid = 1'b0;
	logic                stall = 1'b0;
	logic                rep_ready, tx_valid, tx_ready;
	logic [7:0]          tx_data;
	aef_pkg::aef_reply_s rep = '0;
	int                  seed = 32'h1AAA;
	int                  num_errors = 0;
	int                  total_checks = 0;
	int                  cyc = 0;
	always #25 clk = ~clk;
	always @(posedge clk) cyc <= rst_b ? cyc + 1 : 0;
	aef_encoder aef_encoder_i (.clk, .rst_b, .rep, .rep_valid, .rep_ready,
		.tx_data, .tx_valid, .tx_ready);
	aef_host aef_host_i (.clk, .tx_data, .tx_valid, .stall, .tx_ready);
	task check(input logic [47:0] seen, input logic [47:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task close_out;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	function int len(input int k);
		return k == 0 ? 2 : k == 1 ? 7 : 14;
	endfunction
	task frame(input int i);
		int n, k, t0;
		logic [47:0] ts, ts_exp;
		k = i == 0 ? 2 : {$random(seed)} % 3;
		for (n = 0; n < 100 && rep_ready !== 1'b1; n++) @(negedge clk);
		rep.kind = aef_pkg::aef_kind_e'(k);
		rep.data = i == 0 ? {14{8'h1A}} : 112'({$random(seed),
			$random(seed), $random(seed), $random(seed)});
		rep.level = i % 4 == 0 ? 8'h1A : 8'($random(seed));
		rep.level_ok = i != 1;
		rep.ts_ok = i != 1;
		stall = 1'(i);
		rep_valid = 1'b1;
		@(posedge clk);
		t0 = cyc;
		@(negedge clk);
		rep_valid = 1'b0;
		for (n = 0; n < 300 && (aef_host_i.fr.size() < 8 + len(k)
			|| !rep_ready); n++) @(negedge clk);
		check(aef_host_i.fr.size(), 8 + len(k));
		check(aef_host_i.raw <= 2 + 2 * (7 + len(k)), 1'b1);
		check(aef_host_i.fr[0], 8'h31 + k);
		ts = '0;
		for (n = 1; n < 7; n++) ts = {ts[39:0], aef_host_i.fr[n]};
		ts_exp = 48'(aef_pkg::TICK_MHZ * t0 / aef_pkg::CLK_MHZ);
		if (i == 1)
			check(ts, 48'h0);
		else
			check(ts, ts_exp);
		check(aef_host_i.fr[7], rep.level_ok ? rep.level : 8'hFF);
		for (n = 0; n < len(k); n++)
			check(aef_host_i.fr[8 + n], rep.data[111 - 8 * n -: 8]);
	endtask
	initial
	begin
		repeat (8) @(negedge clk);
		rst_b = 1'b1;
		for (int i = 0; i < 30; i++) frame(i);
		close_out();
	end
	initial
	begin
		#(20000 * 50);
		num_errors++;
		close_out();
	end
endmodule

// >>> test/aef_host.sv
// Host receiver model: random stalls, unstuffing and resync
`timescale 1ns/1ps
module aef_host
(
	input  logic       clk,
	input  logic [7:0] tx_data,
	input  logic       tx_valid,
	input  logic       stall,
	output logic       tx_ready
);
	logic [7:0] fr[$];
	logic       esc = 1'b0;
	int         raw = 0;
	int         seed = 32'h1AAA;
	initial tx_ready = 1'b0;
	always @(negedge clk)
		tx_ready <= !stall || ($random(seed) & 1);
	always @(posedge clk)
		if (tx_valid && tx_ready)
		begin
			if (esc && tx_data != 8'h1A)
				fr = {tx_data};
			else if (esc || tx_data != 8'h1A)
				fr.push_back(tx_data);
			raw = esc && tx_data != 8'h1A ? 2 : raw + 1;
			esc = !esc && tx_data == 8'h1A;
		end
endmodule

// >>> verilog/aef_encoder.sv
// Escaped frame encoder: reply capture, free timestamp and byte stuffing
`timescale 1ns/1ps
module aef_encoder
(
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire aef_pkg::aef_reply_s rep,
	input  wire logic              rep_valid,
	output logic                   rep_ready,
	output logic [7:0]             tx_data,
	output logic                   tx_valid,
	input  wire logic              tx_ready
);

	//--------------------------------------------------------------------------
	// Types and functions
	//--------------------------------------------------------------------------
	typedef enum logic [1:0] {
		AEF_IDLE,
		AEF_SEND,
		AEF_DRAIN
	} aef_state_e;

	function automatic logic [4:0] last_idx(aef_pkg::aef_kind_e k);
		logic [4:0] n;
		n = 5'(aef_pkg::LEN_LONG);
		unique case (k)
			aef_pkg::AEF_AC:    n = 5'(aef_pkg::LEN_AC);
			aef_pkg::AEF_SHORT: n = 5'(aef_pkg::LEN_SHORT);
			aef_pkg::AEF_LONG:  n = 5'(aef_pkg::LEN_LONG);
			default:            n = 5'(aef_pkg::LEN_LONG);
		endcase
		return aef_pkg::IDX_DATA + n - 5'h01; // RL4
	endfunction

	function automatic logic [7:0] type_code(aef_pkg::aef_kind_e k);
		logic [7:0] t;
		t = aef_pkg::TYPE_LONG;
		unique case (k)
			aef_pkg::AEF_AC:    t = aef_pkg::TYPE_AC; // RL4
			aef_pkg::AEF_SHORT: t = aef_pkg::TYPE_SHORT;
			aef_pkg::AEF_LONG:  t = aef_pkg::TYPE_LONG;
			default:            t = aef_pkg::TYPE_LONG;
		endcase
		return t;
	endfunction

	//--------------------------------------------------------------------------
	// Free-running timestamp counter
	//--------------------------------------------------------------------------
	logic [4:0]               acc_ff;
	logic [4:0]               nxt_acc;
	logic [aef_pkg::TS_W-1:0] cnt_ff;
	logic [aef_pkg::TS_W-1:0] nxt_cnt;

	always_comb
	begin
		nxt_acc = acc_ff + aef_pkg::ACC_STEP;
		nxt_cnt = cnt_ff;
		if (nxt_acc >= aef_pkg::ACC_WRAP) // RL5
		begin
			nxt_acc = nxt_acc - aef_pkg::ACC_WRAP;
			nxt_cnt = cnt_ff + 48'h000000000001; // RL6
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			acc_ff <= 5'h00;
			cnt_ff <= 48'h000000000000;
		end
		else
		begin
			acc_ff <= nxt_acc;
			cnt_ff <= nxt_cnt;
		end
	end

	//--------------------------------------------------------------------------
	// Frame sequencer
	//--------------------------------------------------------------------------
	aef_state_e               state_ff;
	aef_state_e               nxt_state;
	aef_pkg::aef_reply_s      rep_ff;
	aef_pkg::aef_reply_s      nxt_rep;
	logic [aef_pkg::TS_W-1:0] ts_ff;
	logic [aef_pkg::TS_W-1:0] nxt_ts;
	logic [4:0]               idx_ff;
	logic [4:0]               nxt_idx;
	logic                     dup_ff;
	logic                     nxt_dup;
	logic [7:0]               tx_data_ff;
	logic [7:0]               nxt_tx_data;
	logic                     tx_valid_ff;
	logic                     nxt_tx_valid;
	logic                     ready_ff;
	logic                     nxt_ready;
	logic                     slot_free;
	logic [7:0]               body;
	logic [4:0]               dbyte;

	assign slot_free = !tx_valid_ff || tx_ready; // RL11

	// Byte of the frame body at the current index
	always_comb
	begin
		dbyte = idx_ff - aef_pkg::IDX_DATA;
		body  = aef_pkg::TS_NONE;
		if (idx_ff == 5'h00)
			body = type_code(rep_ff.kind); // RL3
		else if (idx_ff < aef_pkg::IDX_LEVEL)
			body = ts_ff[aef_pkg::TS_W - 8*int'(idx_ff) +: 8]; // RL5
		else if (idx_ff == aef_pkg::IDX_LEVEL)
			body = rep_ff.level_ok ? rep_ff.level
				: aef_pkg::LEVEL_NONE; // RL8
		else
			body = rep_ff.data[aef_pkg::DATA_BYTES*8 - 8 - 8*int'(dbyte) +: 8];
	end

	always_comb
	begin
		nxt_state    = state_ff;
		nxt_rep      = rep_ff;
		nxt_ts       = ts_ff;
		nxt_idx      = idx_ff;
		nxt_dup      = dup_ff;
		nxt_tx_data  = tx_data_ff;
		nxt_tx_valid = tx_valid_ff;
		nxt_ready    = ready_ff;
		unique case (state_ff)
			AEF_IDLE:
			begin
				if (tx_ready)
					nxt_tx_valid = 1'b0;
				if (rep_valid && ready_ff && slot_free)
				begin
					nxt_rep      = rep;
					nxt_ts       = rep.ts_ok ? cnt_ff
						: {aef_pkg::TS_BYTES{aef_pkg::TS_NONE}}; // RL7
					nxt_ready    = 1'b0; // RL11
					nxt_idx      = 5'h00;
					nxt_dup      = 1'b0;
					nxt_tx_data  = aef_pkg::MARKER; // RL3
					nxt_tx_valid = 1'b1;
					nxt_state    = AEF_SEND;
				end
			end
			AEF_SEND:
			begin
				if (slot_free)
				begin
					nxt_tx_valid = 1'b1;
					if (dup_ff)
					begin
						nxt_tx_data = aef_pkg::MARKER; // RL1
						nxt_dup     = 1'b0;
					end
					else
					begin
						nxt_tx_data = body;
						nxt_dup     = (body == aef_pkg::MARKER); // RL10
					end
					if (dup_ff || body != aef_pkg::MARKER)
					begin
						nxt_idx = idx_ff + 5'h01;
						if (idx_ff == last_idx(rep_ff.kind))
							nxt_state = AEF_DRAIN; // RL9
					end
				end
			end
			AEF_DRAIN:
			begin
				if (slot_free)
				begin
					nxt_tx_valid = 1'b0;
					nxt_ready    = 1'b1;
					nxt_state    = AEF_IDLE;
				end
			end
			default:
			begin
				nxt_state    = AEF_IDLE;
				nxt_tx_valid = 1'b0;
				nxt_ready    = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_ff    <= AEF_IDLE;
			rep_ff      <= '0;
			ts_ff       <= 48'h000000000000;
			idx_ff      <= 5'h00;
			dup_ff      <= 1'b0;
			tx_data_ff  <= 8'h00;
			tx_valid_ff <= 1'b0;
			ready_ff    <= 1'b1;
		end
		else
		begin
			state_ff    <= nxt_state;
			rep_ff      <= nxt_rep;
			ts_ff       <= nxt_ts;
			idx_ff      <= nxt_idx;
			dup_ff      <= nxt_dup;
			tx_data_ff  <= nxt_tx_data;
			tx_valid_ff <= nxt_tx_valid;
			ready_ff    <= nxt_ready;
		end
	end

	assign tx_data   = tx_data_ff;
	assign tx_valid  = tx_valid_ff;
	assign rep_ready = ready_ff;

endmodule
